// ---- ccl_pkg.sv ----
// Purpose: Shared constants for the charger limit registers and overcurrent sequence
// Assumes: 200 MHz system clock; SMBus framing decoded outside into word commands
// Notes: Register fields hold only the implemented bits; readback rebuilds the word
package ccl_pkg;
  // Command codes
  localparam logic [7:0] CMD_CHARGE_CURRENT = 8'h14;
  localparam logic [7:0] CMD_RELEARN = 8'h3D;
  localparam logic [7:0] CMD_INPUT_LIMIT = 8'h3F;
  // Current setting field layout, shared by both current registers
  localparam int CODE_LSB = 7;
  localparam int CODE_W = 6;
  // Relearn word layout
  localparam int RELEARN_EN_BIT = 0;
  localparam int RELEARN_LSB = 4;
  localparam int RELEARN_W = 11;
  // Reset values
  localparam logic [15:0] CHARGE_CURRENT_RST = 16'h0000;
  localparam logic [15:0] INPUT_LIMIT_RST = 16'h1000;
  localparam logic [15:0] RELEARN_RST = 16'h4B00;
  // Lowest usable relearn threshold, 4096 mV in 16 mV steps
  localparam logic [RELEARN_W-1:0] RELEARN_MIN_CODE = 11'h100;
  // Smallest nonzero input limit code, 128 mA
  localparam logic [CODE_W-1:0] INPUT_LIMIT_MIN_CODE = 6'h01;
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int OCP_QUAL_MS = 16;
  localparam int RETRY_WAIT_MS = 600;
  localparam int OCP_QUAL_CYC = OCP_QUAL_MS * CLK_MHZ * 1000;
  localparam int RETRY_WAIT_CYC = RETRY_WAIT_MS * CLK_MHZ * 1000;
  localparam int TIMER_W = 27;
  localparam logic [1:0] MAX_RETRIES = 2'h3;
  // Overcurrent sequence states
  typedef enum logic [1:0] {
    OCP_IDLE = 2'b00,
    OCP_QUAL = 2'b01,
    OCP_OFF = 2'b10,
    OCP_LATCH = 2'b11
  } ccl_ocp_state_t;
endpackage

// ---- ccl_timer.sv ----
// Purpose: One-shot down counter for the qualification and retry delays
// Assumes: load_in is at least 1 when start_in pulses
// Notes: expired_out is high for one cycle, load_in cycles after the start edge
`timescale 1ns/1ps
module ccl_timer #(
  parameter int W = ccl_pkg::TIMER_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Control
  input wire logic start_in,
  input wire logic cancel_in,
  input wire logic [W-1:0] load_in,
  // Status
  output logic expired_out
);
  import ccl_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
    logic expired;
  } ccl_tmr_state_t;

  ccl_tmr_state_t st_r;
  ccl_tmr_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.expired = 1'b0;
    if (cancel_in) begin
      st_nxt.run = 1'b0;
    end else if (start_in) begin
      st_nxt.cnt = load_in;
      st_nxt.run = 1'b1;
    end else if (st_r.run) begin
      if (st_r.cnt <= W'(1)) begin
        st_nxt.run = 1'b0;
        st_nxt.expired = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expired_out = st_r.expired;
endmodule // ccl_timer

// ---- ccl_charger_regs.sv ----
// Purpose: Charger current/relearn setting registers with overcurrent retry and relearn sequences
// Assumes: Word commands arrive already decoded from SMBus; analog comparators are synchronous inputs
// Notes: Readback rebuilds each word; unused bits read as zero
`timescale 1ns/1ps
module ccl_charger_regs #(
  parameter int QUAL_CYCLES = ccl_pkg::OCP_QUAL_CYC,
  parameter int RETRY_CYCLES = ccl_pkg::RETRY_WAIT_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Word command port
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] wr_data_in,
  output logic [15:0] rd_data_out,
  output logic rd_valid_out,
  output logic rd_ack_out,
  // Analog monitors
  input wire logic adapter_present_in,
  input wire logic input_over_limit_in,
  input wire logic adapter_overcurrent_trip_in,
  input wire logic [15:0] batt_voltage_in,
  // Controls to the power stage
  output logic adapter_select_drive_out,
  output logic [ccl_pkg::CODE_W-1:0] charge_current_code_out,
  output logic [ccl_pkg::CODE_W-1:0] input_limit_code_out,
  output logic [ccl_pkg::RELEARN_W-1:0] relearn_field_out,
  output logic ocp_latched_out
);
  import ccl_pkg::*;

  typedef struct packed {
    logic [CODE_W-1:0] chg_code;
    logic [CODE_W-1:0] lim_code;
    logic lim_min_req;
    logic [RELEARN_W-1:0] relearn_code;
    logic relearn_en;
    logic [CODE_W-1:0] chg_applied;
    logic [CODE_W-1:0] lim_eff;
    ccl_ocp_state_t ocp;
    logic [1:0] trips;
    logic sel_drive;
    logic latched;
    logic [15:0] rd_data;
    logic rd_valid;
    logic rd_ack;
  } ccl_regs_state_t;

  ccl_regs_state_t st_r;
  ccl_regs_state_t st_nxt;
  logic tmr_start;
  logic tmr_cancel;
  logic [TIMER_W-1:0] tmr_load;
  logic tmr_expired;
  logic [RELEARN_W-1:0] relearn_thr;
  logic relearn_set;

  ccl_timer #(
    .W(TIMER_W)
  ) u_timer (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .start_in(tmr_start),
    .cancel_in(tmr_cancel),
    .load_in(tmr_load),
    .expired_out(tmr_expired)
  );

  always_comb begin
    st_nxt = st_r;
    tmr_start = 1'b0;
    tmr_cancel = 1'b0;
    tmr_load = TIMER_W'(QUAL_CYCLES);
    relearn_set = 1'b0;
    st_nxt.rd_valid = 1'b0;
    st_nxt.rd_ack = 1'b0;
    // Writes keep only the implemented field bits
    if (wr_en_in) begin
      unique case (cmd_code_in)
        CMD_CHARGE_CURRENT: begin
          st_nxt.chg_code = wr_data_in[CODE_LSB +: CODE_W];
        end
        CMD_INPUT_LIMIT: begin
          st_nxt.lim_code = wr_data_in[CODE_LSB +: CODE_W];
          st_nxt.lim_min_req = |wr_data_in[CODE_LSB-1:0];
        end
        CMD_RELEARN: begin
          st_nxt.relearn_code = wr_data_in[RELEARN_LSB +: RELEARN_W];
          st_nxt.relearn_en = wr_data_in[RELEARN_EN_BIT];
          relearn_set = wr_data_in[RELEARN_EN_BIT];
        end
        default: begin
        end
      endcase
    end
    // Sub-128 mA requests read back as zero but still apply the minimum step
    if (st_r.lim_code == '0 && st_r.lim_min_req) begin
      st_nxt.lim_eff = INPUT_LIMIT_MIN_CODE;
    end else begin
      st_nxt.lim_eff = st_r.lim_code;
    end
    // Fold back one step per cycle so the system load keeps the input budget
    if (st_r.chg_applied > st_r.chg_code) begin
      st_nxt.chg_applied = st_r.chg_code;
    end else if (input_over_limit_in && st_r.chg_applied != '0) begin
      st_nxt.chg_applied = st_r.chg_applied - CODE_W'(1);
    end else if (!input_over_limit_in && st_r.chg_applied < st_r.chg_code) begin
      st_nxt.chg_applied = st_r.chg_applied + CODE_W'(1);
    end
    // End relearn at the threshold; a fresh enable write in the same cycle wins
    if (st_r.relearn_en && !relearn_set && batt_voltage_in[RELEARN_LSB +: RELEARN_W] <= relearn_thr) begin
      st_nxt.relearn_en = 1'b0;
    end
    // Overcurrent qualification, retry and latch-off
    if (!adapter_present_in) begin
      st_nxt.ocp = OCP_IDLE;
      st_nxt.trips = 2'h0;
      tmr_cancel = 1'b1;
    end else begin
      unique case (st_r.ocp)
        OCP_IDLE: begin
          if (adapter_overcurrent_trip_in) begin
            tmr_start = 1'b1;
            st_nxt.ocp = OCP_QUAL;
          end
        end
        OCP_QUAL: begin
          if (!adapter_overcurrent_trip_in) begin
            tmr_cancel = 1'b1;
            st_nxt.ocp = OCP_IDLE;
          end else if (tmr_expired) begin
            if (st_r.trips == MAX_RETRIES) begin
              st_nxt.ocp = OCP_LATCH;
            end else begin
              st_nxt.trips = st_r.trips + 2'h1;
              tmr_start = 1'b1;
              tmr_load = TIMER_W'(RETRY_CYCLES);
              st_nxt.ocp = OCP_OFF;
            end
          end
        end
        OCP_OFF: begin
          tmr_load = TIMER_W'(RETRY_CYCLES);
          if (tmr_expired) begin
            st_nxt.ocp = OCP_IDLE;
          end
        end
        OCP_LATCH: begin
        end
      endcase
    end
    // Adapter connected only while present, idle or qualifying a trip, and not relearning
    st_nxt.sel_drive = adapter_present_in && !st_nxt.relearn_en &&
                       (st_nxt.ocp == OCP_IDLE || st_nxt.ocp == OCP_QUAL);
    // Registered so the latch flag changes on the same edge as the selector
    st_nxt.latched = (st_nxt.ocp == OCP_LATCH);
    // Readback rebuilds the word with unused bits as zero
    if (rd_en_in) begin
      st_nxt.rd_valid = 1'b1;
      st_nxt.rd_data = 16'h0000;
      unique case (cmd_code_in)
        CMD_CHARGE_CURRENT: begin
          st_nxt.rd_data = {3'h0, st_r.chg_code, 7'h00};
          st_nxt.rd_ack = 1'b1;
        end
        CMD_INPUT_LIMIT: begin
          st_nxt.rd_data = {3'h0, st_r.lim_code, 7'h00};
          st_nxt.rd_ack = 1'b1;
        end
        CMD_RELEARN: begin
          st_nxt.rd_data = {1'b0, st_r.relearn_code, 3'h0, st_r.relearn_en};
          st_nxt.rd_ack = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // Codes below 4.096 V are raised to the floor of the threshold range
  assign relearn_thr = (st_r.relearn_code < RELEARN_MIN_CODE) ? RELEARN_MIN_CODE : st_r.relearn_code;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
      st_r.chg_code <= CHARGE_CURRENT_RST[CODE_LSB +: CODE_W];
      st_r.lim_code <= INPUT_LIMIT_RST[CODE_LSB +: CODE_W];
      st_r.lim_eff <= INPUT_LIMIT_RST[CODE_LSB +: CODE_W];
      st_r.relearn_code <= RELEARN_RST[RELEARN_LSB +: RELEARN_W];
      st_r.relearn_en <= RELEARN_RST[RELEARN_EN_BIT];
      st_r.ocp <= OCP_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data_out = st_r.rd_data;
  assign rd_valid_out = st_r.rd_valid;
  assign rd_ack_out = st_r.rd_ack;
  assign adapter_select_drive_out = st_r.sel_drive;
  assign charge_current_code_out = st_r.chg_applied;
  assign input_limit_code_out = st_r.lim_eff;
  assign relearn_field_out = st_r.relearn_code;
  assign ocp_latched_out = st_r.latched;
endmodule // ccl_charger_regs

// ---- ccl_host_model.sv ----
// Purpose: Word-level host model for the charger command port
// Assumes: One strobe per word, taken at a rising edge
// Notes: Released lines show inverted values so stale data cannot pass
`timescale 1ns/1ps
module ccl_host_model (
  // Clock
  input wire logic clk_in,
  // Command port
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] cmd_out,
  output logic [15:0] data_out,
  input wire logic [15:0] rd_data_in,
  input wire logic rd_ack_in
);
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    cmd_out = 8'h00;
    data_out = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q, output logic a);
    @(posedge clk_in);
    wr_en_out <= w;
    rd_en_out <= !w;
    cmd_out <= c;
    data_out <= d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    rd_en_out <= 1'b0;
    cmd_out <= ~c;
    data_out <= ~d;
    @(posedge clk_in);
    q = rd_data_in;
    a = rd_ack_in;
  endtask
endmodule // ccl_host_model

// ---- ccl_charger_regs_properties.sv ----
// Purpose: Port-level checks of the charger registers
// Assumes: Single clock domain, sync reset
// Notes: Timer lengths are checked by the bench
`timescale 1ns/1ps
module ccl_charger_regs_properties (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] wr_data_in,
  input wire logic [15:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic rd_ack_out,
  input wire logic adapter_present_in,
  input wire logic input_over_limit_in,
  input wire logic adapter_select_drive_out,
  input wire logic [5:0] charge_current_code_out,
  input wire logic [5:0] input_limit_code_out,
  input wire logic ocp_latched_out
);
  logic mapped;
  logic lim_wr;
  assign mapped = cmd_code_in inside {8'h14, 8'h3D, 8'h3F};
  assign lim_wr = wr_en_in && cmd_code_in == 8'h3F;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  AST_RD_VALID: assert property (rd_en_in |=> rd_valid_out) else $error("no read answer");
  AST_RD_ACK: assert property (rd_en_in && mapped |=> rd_ack_out) else $error("no ack");
  AST_UNMAPPED: assert property (rd_en_in && !mapped |=> !rd_ack_out && rd_data_out == 16'h0000)
    else $error("unmapped read");
  AST_LIMIT_RD: assert property (rd_en_in && cmd_code_in == 8'h3F |=> (rd_data_out & 16'hE07F) == 16'h0000)
    else $error("unused limit bits");
  AST_WR_LIMIT: assert property (lim_wr && wr_data_in[12:7] != 6'h00
    |=> ##1 input_limit_code_out == $past(wr_data_in[12:7], 2)) else $error("limit code");
  AST_MIN_LIMIT: assert property (lim_wr && wr_data_in[12:7] == 6'h00 && wr_data_in[6:0] != 7'h00
    |=> ##1 input_limit_code_out == 6'h01) else $error("min limit");
  AST_FOLDBACK: assert property (input_over_limit_in && charge_current_code_out != 6'h00
    |=> charge_current_code_out < $past(charge_current_code_out)) else $error("no foldback");
  AST_LATCH_SEL: assert property ($past(ocp_latched_out) && ocp_latched_out |-> !adapter_select_drive_out)
    else $error("latched but connected");
  AST_REMOVE: assert property (!adapter_present_in |=> !ocp_latched_out) else $error("latch kept");
endmodule // ccl_charger_regs_properties
bind ccl_charger_regs ccl_charger_regs_properties ccl_charger_regs_properties_i (.clk_in, .sys_rst_in,
  .wr_en_in, .rd_en_in, .cmd_code_in, .wr_data_in, .rd_data_out, .rd_valid_out, .rd_ack_out,
  .adapter_present_in, .input_over_limit_in, .adapter_select_drive_out, .charge_current_code_out,
  .input_limit_code_out, .ocp_latched_out);

// ---- ccl_charger_regs_tb.sv ----
// Purpose: Self-checking bench for the charger registers and sequences
// Assumes: Short timers of 20 and 50 cycles
// Notes: Expected values come from bench functions and literal constants
`timescale 1ns/1ps
module ccl_charger_regs_tb;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic wr_en, rd_en, rd_valid, rd_ack, a, sel, latched;
  logic present = 1'b1, over = 1'b0, trip = 1'b0;
  logic [7:0] cmd, c;
  logic [15:0] wdata, rdata, q, d;
  logic [15:0] batt = 16'h7FF0;
  logic [5:0] chg, lim;
  logic [10:0] relearn;
  logic [31:0] seed = 32'h000052FE;
  logic [7:0] cmds [4] = '{8'h14, 8'h3D, 8'h3F, 8'h5A};
  logic [15:0] corner [3] = '{16'h007F, 16'h1F80, 16'hE000};
  int failures = 0, n_checks = 0, n;
  always #2.5 clk_in = ~clk_in;
  ccl_charger_regs #(.QUAL_CYCLES(20), .RETRY_CYCLES(50)) ccl_charger_regs_i (.clk_in, .sys_rst_in,
    .wr_en_in(wr_en), .rd_en_in(rd_en), .cmd_code_in(cmd), .wr_data_in(wdata), .rd_data_out(rdata),
    .rd_valid_out(rd_valid), .rd_ack_out(rd_ack), .adapter_present_in(present), .input_over_limit_in(over),
    .adapter_overcurrent_trip_in(trip), .batt_voltage_in(batt), .adapter_select_drive_out(sel),
    .charge_current_code_out(chg), .input_limit_code_out(lim), .relearn_field_out(relearn),
    .ocp_latched_out(latched));
  ccl_host_model ccl_host_model_i (.clk_in, .wr_en_out(wr_en), .rd_en_out(rd_en), .cmd_out(cmd),
    .data_out(wdata), .rd_data_in(rdata), .rd_ack_in(rd_ack));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [15:0] exp_rd(input logic [7:0] k, input logic [15:0] v);
    case (k)
      8'h14, 8'h3F: return v & 16'h1F80;
      8'h3D: return v & 16'h7FF1;
      default: return 16'h0000;
    endcase
  endfunction
  function automatic logic [15:0] exp_lim(input logic [15:0] v);
    return v[12:7] != 6'h00 ? {10'h000, v[12:7]} : {15'h0000, v[6:0] != 7'h00};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] k, input logic [15:0] v);
    ccl_host_model_i.xfer(1'b1, k, v, q, a);
  endtask
  task automatic rd(input logic [7:0] k);
    ccl_host_model_i.xfer(1'b0, k, 16'h0000, q, a);
  endtask
  // Bounded so a stuck selector ends in a mismatch, not a hang
  task automatic wait_sel(input logic v);
    n = 0;
    while (sel !== v && n < 200) begin
      @(negedge clk_in);
      n++;
    end
  endtask
  task automatic close_out;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    close_out;
  end
  initial begin
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(8'h14);
    chk(q, 16'h0000);
    rd(8'h3F);
    chk(q, 16'h1000);
    rd(8'h3D);
    chk(q, 16'h4B00);
    $display("done reset");
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      c = i < 3 ? 8'h3F : cmds[seed[1:0]];
      d = i < 3 ? corner[i] : seed[31:16] & 16'hBFFF;
      @(posedge clk_in);
      over <= seed[3];
      wr(c, d);
      rd(c);
      chk(q, exp_rd(c, d));
      chk({15'h0000, a}, {15'h0000, c != 8'h5A});
      if (c == 8'h3F) chk({10'h000, lim}, exp_lim(d));
    end
    $display("done random");
    @(posedge clk_in);
    over <= 1'b0;
    wr(8'h14, 16'h1F80);
    repeat (70) @(posedge clk_in);
    chk({10'h000, chg}, 16'h003F);
    over <= 1'b1;
    repeat (70) @(posedge clk_in);
    chk({10'h000, chg}, 16'h0000);
    over <= 1'b0;
    $display("done charge");
    wr(8'h3D, 16'h2001);
    repeat (3) @(posedge clk_in);
    chk({15'h0000, sel}, 16'h0000);
    batt <= 16'h2000;
    repeat (4) @(posedge clk_in);
    chk({15'h0000, sel}, 16'h0001);
    chk({5'h00, relearn}, 16'h0200);
    rd(8'h3D);
    chk(q, 16'h2000);
    $display("done relearn");
    repeat (2) begin
      @(posedge clk_in);
      trip <= 1'b1;
      repeat (15) @(posedge clk_in);
      trip <= 1'b0;
    end
    repeat (30) @(posedge clk_in);
    chk({15'h0000, sel}, 16'h0001);
    trip <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wait_sel(1'b0);
      chk(16'(n inside {[20:26]}), 16'h0001);
      if (i < 3) begin
        wait_sel(1'b1);
        chk(16'(n inside {[50:56]}), 16'h0001);
      end
    end
    repeat (80) @(posedge clk_in);
    chk({14'h0000, sel, latched}, 16'h0001);
    present <= 1'b0;
    trip <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk({15'h0000, latched}, 16'h0000);
    present <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk({15'h0000, sel}, 16'h0001);
    $display("done overcurrent");
    close_out;
  end
endmodule // ccl_charger_regs_tb
